// file: spr_pkg.sv
// Package: constants, types and register map of the setpoint relay block
// Contract
// [R1] Low-trip: relay and indicator on below threshold
// [R2] High-trip: relay and indicator on above threshold
// [R3] Combined: upper and lower threshold, either trips
// [R4] Reset thresholds equal lowest measurable pressure
// [R5] Mode and hysteresis writable by host only
// [R6] Thresholds set by buttons or host
// [R7] Combined mode: button adjusts lower threshold only
// [R8] Session shows threshold on measurement output
// [R9] Press enters session, blinks switching symbol
// [R10] Held button ramps threshold until release or limit
// [R11] Repeat press within one second steps once
// [R12] Repeat press two to three seconds reverses
// [R13] Released over five seconds: save, leave session
// [R14] Session flashes selected channel indicator
// [R15] Version shown briefly after power-up
// [R16] Host can flip display half a turn
// [R17] Default hysteresis ten percent beyond trip point
// [R18] Buttons synchronised and debounced before timing
package spr_pkg;
	localparam int unsigned CLK_HZ     = 250000000;
	localparam int unsigned CLK_KHZ    = 250000;
	localparam int unsigned T_FINE_S   = 1;
	localparam int unsigned T_REVLO_S  = 2;
	localparam int unsigned T_REVHI_S  = 3;
	localparam int unsigned T_SAVE_S   = 5;
	localparam int unsigned T_SHOW_S   = 5;
	localparam int unsigned T_STEP_MS  = 50;
	localparam int unsigned T_DEB_MS   = 10;
	localparam int unsigned T_VER_MS   = 2000;
	localparam int unsigned T_BLINK_MS = 250;
	localparam int unsigned FINE_CYC   = T_FINE_S * CLK_HZ;
	localparam int unsigned REVLO_CYC  = T_REVLO_S * CLK_HZ;
	localparam int unsigned REVHI_CYC  = T_REVHI_S * CLK_HZ;
	localparam int unsigned SAVE_CYC   = T_SAVE_S * CLK_HZ;
	localparam int unsigned SHOW_CYC   = T_SHOW_S * CLK_HZ;
	localparam int unsigned STEP_CYC   = T_STEP_MS * CLK_KHZ;
	localparam int unsigned DEB_CYC    = T_DEB_MS * CLK_KHZ;
	localparam int unsigned VER_CYC    = T_VER_MS * CLK_KHZ;
	localparam int unsigned BLINK_CYC  = T_BLINK_MS * CLK_KHZ;
	localparam int unsigned PW         = 16;
	localparam int unsigned AW         = 8;
	localparam logic [15:0] PMIN       = 16'h0000;
	localparam logic [15:0] PMAX       = 16'hffff;
	localparam logic [7:0]  HYST_DEF   = 8'h0a;
	localparam logic [7:0]  PCT        = 8'h64;
	localparam logic [31:0] VERSION    = 32'h0000_0100;
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_MODE     = 8'h04;
	localparam logic [7:0]  A_HYST     = 8'h08;
	localparam logic [7:0]  A_SP1_LO   = 8'h0c;
	localparam logic [7:0]  A_SP1_HI   = 8'h10;
	localparam logic [7:0]  A_SP2_LO   = 8'h14;
	localparam logic [7:0]  A_SP2_HI   = 8'h18;
	localparam logic [7:0]  A_STATUS   = 8'h1c;
	localparam logic [7:0]  A_IRQ_STAT = 8'h20;
	localparam logic [7:0]  A_IRQ_MASK = 8'h24;
	localparam logic [7:0]  A_VERSION  = 8'h28;
	localparam int unsigned IRQ_W      = 3;
	localparam int unsigned IRQ_SAVE   = 2;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	typedef enum logic [1:0] {
		SPR_LOW  = 2'h0,
		SPR_HIGH = 2'h1,
		SPR_BOTH = 2'h2
	} spr_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HELD = 2'b01,
		ST_REL  = 2'b11,
		ST_SAVE = 2'b10
	} spr_state_t;
	typedef struct packed {
		spr_mode_t   mode;
		logic [7:0]  hyst;
		logic [15:0] lo;
		logic [15:0] hi;
	} spr_chan_t;
endpackage

// file: spr_top.sv
// Setpoint relay switching: two channels, button adjust, AXI4-Lite registers
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
module spr_top #(
	parameter int unsigned FINE_CYC  = spr_pkg::FINE_CYC,
	parameter int unsigned REVLO_CYC = spr_pkg::REVLO_CYC,
	parameter int unsigned REVHI_CYC = spr_pkg::REVHI_CYC,
	parameter int unsigned SAVE_CYC  = spr_pkg::SAVE_CYC,
	parameter int unsigned SHOW_CYC  = spr_pkg::SHOW_CYC,
	parameter int unsigned STEP_CYC  = spr_pkg::STEP_CYC,
	parameter int unsigned DEB_CYC   = spr_pkg::DEB_CYC,
	parameter int unsigned VER_CYC   = spr_pkg::VER_CYC,
	parameter int unsigned BLINK_CYC = spr_pkg::BLINK_CYC
) (
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] pressure,
	input  wire logic [1:0]  button_raw,
	output logic [1:0]       relay_close,
	output logic [1:0]       indicator_on,
	output logic [15:0]      meas_out,
	output logic             sw_symbol_blink,
	output logic             show_version,
	output logic             display_flip,
	output logic             store_pulse,
	output logic             irq
);
	spr_pkg::spr_chan_t  cfg_q [2];
	spr_pkg::spr_state_t st_q;
	logic [1:0]  btn_s1_q, btn_s2_q, btn_db, btn_prev_q, press_ev, rel_ev;
	logic        sel_q, dir_q, blink_q;
	logic [31:0] tmr_q, step_q, blink_cnt_q, ver_cnt_q;
	logic [1:0]  trip_lo_q, trip_hi_q, trip_lo_d, trip_hi_d, relay_d;
	logic [spr_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
	logic        aw_have_q, w_have_q, aw_next, w_next, aw_fire, w_fire, ar_fire, wr_go;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q, wval, rd_mux, wr_old;
	logic [3:0]  w_strb_q;
	logic        map_ok_w, map_ok_r;
	logic        sel_press, sel_rel, ramp_tick, fine_step, rev_dir, adj_go, tgt_hi;
	logic [15:0] thr_sel;

	function automatic logic [15:0] hy_amt(input logic [15:0] th, input logic [7:0] h);
		logic [23:0] prod;
		prod = th * h;
		return 16'(prod / 24'(spr_pkg::PCT));
	endfunction

	function automatic logic [15:0] step_thr(input logic [15:0] v, input logic up);
		if (up) begin
			return (v == spr_pkg::PMAX) ? v : v + 16'h1;
		end
		return (v == spr_pkg::PMIN) ? v : v - 16'h1;
	endfunction

	function automatic logic [31:0] reg_rd(input logic [7:0] a);
		case (a)
			spr_pkg::A_CTRL:     return {31'h0, display_flip};
			spr_pkg::A_MODE:     return {28'h0, cfg_q[1].mode, cfg_q[0].mode};
			spr_pkg::A_HYST:     return {16'h0, cfg_q[1].hyst, cfg_q[0].hyst};
			spr_pkg::A_SP1_LO:   return {16'h0, cfg_q[0].lo};
			spr_pkg::A_SP1_HI:   return {16'h0, cfg_q[0].hi};
			spr_pkg::A_SP2_LO:   return {16'h0, cfg_q[1].lo};
			spr_pkg::A_SP2_HI:   return {16'h0, cfg_q[1].hi};
			spr_pkg::A_STATUS:   return {25'h0, show_version, dir_q, sel_q, st_q, relay_close};
			spr_pkg::A_IRQ_STAT: return {29'h0, irq_stat_q};
			spr_pkg::A_IRQ_MASK: return {29'h0, irq_mask_q};
			spr_pkg::A_VERSION:  return spr_pkg::VERSION;
			default:             return 32'h0;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a <= spr_pkg::A_VERSION) && (a[1:0] == 2'h0);
	endfunction

	// Pin synchroniser; first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_s1_q <= 2'h0;
			btn_s2_q <= 2'h0;
		end else begin
			btn_s1_q <= button_raw; // R18
			btn_s2_q <= btn_s1_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_deb
			logic [31:0] cnt_q;
			logic        stable_q;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt_q    <= 32'h0;
					stable_q <= 1'b0;
				end else if (btn_s2_q[gi] == stable_q) begin
					cnt_q <= 32'h0;
				end else if (cnt_q >= DEB_CYC - 1) begin
					cnt_q    <= 32'h0;
					stable_q <= btn_s2_q[gi]; // R18
				end else begin
					cnt_q <= cnt_q + 32'h1;
				end
			end
		end
	endgenerate
	assign btn_db = {g_deb[1].stable_q, g_deb[0].stable_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_prev_q <= 2'h0;
		end else begin
			btn_prev_q <= btn_db;
		end
	end
	assign press_ev  = btn_db & ~btn_prev_q;
	assign rel_ev    = ~btn_db & btn_prev_q;
	assign sel_press = press_ev[sel_q];
	assign sel_rel   = rel_ev[sel_q];

	// Button session
	assign ramp_tick = (st_q == spr_pkg::ST_HELD) && (tmr_q >= SHOW_CYC)
		&& (step_q == STEP_CYC - 1); // R10
	assign fine_step = (st_q == spr_pkg::ST_REL) && sel_press && (tmr_q <= FINE_CYC); // R11
	assign rev_dir   = (st_q == spr_pkg::ST_REL) && sel_press && (tmr_q >= REVLO_CYC)
		&& (tmr_q <= REVHI_CYC); // R12
	assign adj_go    = ramp_tick | fine_step;
	assign tgt_hi    = (cfg_q[sel_q].mode == spr_pkg::SPR_HIGH); // R7
	assign thr_sel   = tgt_hi ? cfg_q[sel_q].hi : cfg_q[sel_q].lo;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q  <= spr_pkg::ST_IDLE;
			sel_q <= 1'b0;
			dir_q <= 1'b1;
			tmr_q <= 32'h0;
		end else begin
			case (st_q)
				spr_pkg::ST_IDLE: begin
					if (press_ev != 2'h0) begin
						st_q  <= spr_pkg::ST_HELD; // R9
						sel_q <= ~press_ev[0];
						dir_q <= 1'b1;
						tmr_q <= 32'h0;
					end
				end
				spr_pkg::ST_HELD: begin
					if (sel_rel) begin
						st_q  <= spr_pkg::ST_REL;
						tmr_q <= 32'h0;
					end else if (tmr_q < SHOW_CYC) begin
						tmr_q <= tmr_q + 32'h1;
					end
				end
				spr_pkg::ST_REL: begin
					if (sel_press) begin
						st_q  <= spr_pkg::ST_HELD;
						tmr_q <= 32'h0;
						if (rev_dir) begin
							dir_q <= ~dir_q; // R12
						end
					end else if (tmr_q >= SAVE_CYC) begin
						st_q <= spr_pkg::ST_SAVE; // R13
					end else begin
						tmr_q <= tmr_q + 32'h1;
					end
				end
				spr_pkg::ST_SAVE: begin
					st_q <= spr_pkg::ST_IDLE; // R13
				end
				default: begin
					st_q <= spr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_q <= 32'h0;
		end else if ((st_q != spr_pkg::ST_HELD) || (tmr_q < SHOW_CYC) || ramp_tick) begin
			step_q <= 32'h0;
		end else begin
			step_q <= step_q + 32'h1;
		end
	end

	// Channel settings; a host write wins over a button step in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < 2; c++) begin
				cfg_q[c].mode <= spr_pkg::SPR_LOW;
				cfg_q[c].hyst <= spr_pkg::HYST_DEF; // R17
				cfg_q[c].lo   <= spr_pkg::PMIN; // R4
				cfg_q[c].hi   <= spr_pkg::PMIN; // R4
			end
		end else if (wr_go) begin
			case (aw_addr_q)
				spr_pkg::A_MODE: begin
					cfg_q[0].mode <= spr_pkg::spr_mode_t'(wval[1:0]); // R5
					cfg_q[1].mode <= spr_pkg::spr_mode_t'(wval[3:2]);
				end
				spr_pkg::A_HYST: begin
					cfg_q[0].hyst <= wval[7:0]; // R5
					cfg_q[1].hyst <= wval[15:8];
				end
				spr_pkg::A_SP1_LO: cfg_q[0].lo <= wval[15:0]; // R6
				spr_pkg::A_SP1_HI: cfg_q[0].hi <= wval[15:0];
				spr_pkg::A_SP2_LO: cfg_q[1].lo <= wval[15:0];
				spr_pkg::A_SP2_HI: cfg_q[1].hi <= wval[15:0];
				default: begin
				end
			endcase
		end else if (adj_go) begin
			if (tgt_hi) begin
				cfg_q[sel_q].hi <= step_thr(cfg_q[sel_q].hi, dir_q); // R6
			end else begin
				cfg_q[sel_q].lo <= step_thr(cfg_q[sel_q].lo, dir_q); // R7
			end
		end
	end

	// Trip evaluation with release point offset by the hysteresis percentage
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			trip_lo_d[c] = (pressure < cfg_q[c].lo) || (trip_lo_q[c] &&
				({1'b0, pressure} <= {1'b0, cfg_q[c].lo} + {1'b0, hy_amt(cfg_q[c].lo,
				cfg_q[c].hyst)})); // R1 R17
			trip_hi_d[c] = (pressure > cfg_q[c].hi) || (trip_hi_q[c] &&
				({1'b0, pressure} + {1'b0, hy_amt(cfg_q[c].hi, cfg_q[c].hyst)} >=
				{1'b0, cfg_q[c].hi})); // R2 R17
			case (cfg_q[c].mode)
				spr_pkg::SPR_HIGH: relay_d[c] = trip_hi_d[c]; // R2
				spr_pkg::SPR_BOTH: relay_d[c] = trip_lo_d[c] | trip_hi_d[c]; // R3
				default:           relay_d[c] = trip_lo_d[c]; // R1
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_lo_q   <= 2'h0;
			trip_hi_q   <= 2'h0;
			relay_close <= 2'h0;
		end else begin
			trip_lo_q   <= trip_lo_d;
			trip_hi_q   <= trip_hi_d;
			relay_close <= relay_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= BLINK_CYC - 1) begin
			blink_cnt_q <= 32'h0;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	// Display side outputs; the threshold replaces pressure for the whole session
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_out        <= 16'h0;
			indicator_on    <= 2'h0;
			sw_symbol_blink <= 1'b0;
			store_pulse     <= 1'b0;
		end else begin
			meas_out        <= (st_q != spr_pkg::ST_IDLE) ? thr_sel : pressure; // R8
			sw_symbol_blink <= (st_q != spr_pkg::ST_IDLE) & blink_q; // R9
			store_pulse     <= (st_q == spr_pkg::ST_SAVE); // R13
			for (int c = 0; c < 2; c++) begin
				indicator_on[c] <= ((st_q != spr_pkg::ST_IDLE) && (sel_q == c[0])) ?
					blink_q : relay_d[c]; // R14
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ver_cnt_q    <= 32'h0;
			show_version <= 1'b1;
		end else if (show_version) begin
			ver_cnt_q    <= ver_cnt_q + 32'h1;
			show_version <= (ver_cnt_q < VER_CYC - 1); // R15
		end
	end

	// Register bus, write side
	assign aw_fire  = s_axi_awvalid & s_axi_awready;
	assign w_fire   = s_axi_wvalid & s_axi_wready;
	assign wr_go    = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign aw_next  = aw_fire | (aw_have_q & ~wr_go);
	assign w_next   = w_fire | (w_have_q & ~wr_go);
	assign map_ok_w = mapped(aw_addr_q);
	assign map_ok_r = mapped(s_axi_araddr);

	always_comb begin
		wr_old = reg_rd(aw_addr_q);
		for (int b = 0; b < 4; b++) begin
			wval[8*b+:8] = w_strb_q[b] ? w_data_q[8*b+:8] : wr_old[8*b+:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h0;
			w_data_q      <= 32'h0;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= spr_pkg::RESP_OKAY;
		end else begin
			aw_have_q     <= aw_next;
			w_have_q      <= w_next;
			s_axi_awready <= ~aw_next;
			s_axi_wready  <= ~w_next;
			if (aw_fire) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= map_ok_w ? spr_pkg::RESP_OKAY : spr_pkg::RESP_SLV;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			display_flip <= 1'b0;
			irq_mask_q   <= '0;
		end else if (wr_go && (aw_addr_q == spr_pkg::A_CTRL)) begin
			display_flip <= wval[0]; // R16
		end else if (wr_go && (aw_addr_q == spr_pkg::A_IRQ_MASK)) begin
			irq_mask_q <= wval[spr_pkg::IRQ_W-1:0];
		end
	end

	// Sticky events, write one to clear; a new event beats a clear
	assign irq_ev = {(st_q == spr_pkg::ST_SAVE), relay_d ^ relay_close};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq       <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
			if (wr_go && (aw_addr_q == spr_pkg::A_IRQ_STAT)) begin
				irq_stat_q <= (irq_stat_q & ~wval[spr_pkg::IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev;
			end
		end
	end

	// Register bus, read side
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	always_comb begin
		rd_mux = reg_rd(s_axi_araddr);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= spr_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= map_ok_r ? spr_pkg::RESP_OKAY : spr_pkg::RESP_SLV;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	property p_low_trip;
		@(posedge aclk) disable iff (!aresetn)
		(cfg_q[0].mode == spr_pkg::SPR_LOW && pressure < cfg_q[0].lo) |=> relay_close[0];
	endproperty
	a_low_trip: assert property (p_low_trip) else $error("low trip missed"); // R1

	property p_high_trip;
		@(posedge aclk) disable iff (!aresetn)
		(cfg_q[1].mode == spr_pkg::SPR_HIGH && pressure > cfg_q[1].hi) |=> relay_close[1];
	endproperty
	a_high_trip: assert property (p_high_trip) else $error("high trip missed"); // R2

	property p_both_trip;
		@(posedge aclk) disable iff (!aresetn)
		(cfg_q[0].mode == spr_pkg::SPR_BOTH && (pressure > cfg_q[0].hi ||
		pressure < cfg_q[0].lo)) |=> relay_close[0];
	endproperty
	a_both_trip: assert property (p_both_trip) else $error("combined trip missed"); // R3

	property p_reset_thr;
		@(posedge aclk) disable iff (!aresetn)
		$past(!aresetn) |-> (cfg_q[0].lo == spr_pkg::PMIN && cfg_q[1].hi == spr_pkg::PMIN
		&& show_version);
	endproperty
	a_reset_thr: assert property (p_reset_thr) else $error("reset values wrong"); // R4 R15

	property p_mode_host;
		@(posedge aclk) disable iff (!aresetn)
		!wr_go |=> $stable(cfg_q[0].mode) && $stable(cfg_q[1].hyst);
	endproperty
	a_mode_host: assert property (p_mode_host) else $error("mode changed without host"); // R5

	property p_meas_thr;
		@(posedge aclk) disable iff (!aresetn)
		(st_q != spr_pkg::ST_IDLE) |=> meas_out == $past(thr_sel) &&
		sw_symbol_blink == $past(blink_q);
	endproperty
	a_meas_thr: assert property (p_meas_thr) else $error("threshold not shown"); // R8 R9

	property p_fine;
		@(posedge aclk) disable iff (!aresetn)
		(fine_step && !wr_go && dir_q && thr_sel != spr_pkg::PMAX) |=>
		thr_sel == $past(thr_sel) + 16'h1;
	endproperty
	a_fine: assert property (p_fine) else $error("fine step wrong"); // R11

	property p_rev;
		@(posedge aclk) disable iff (!aresetn)
		rev_dir |=> dir_q != $past(dir_q) && st_q == spr_pkg::ST_HELD;
	endproperty
	a_rev: assert property (p_rev) else $error("direction not reversed"); // R12

	property p_save;
		@(posedge aclk) disable iff (!aresetn)
		(st_q == spr_pkg::ST_REL && !sel_press && tmr_q >= SAVE_CYC) |=>
		st_q == spr_pkg::ST_SAVE ##1 (st_q == spr_pkg::ST_IDLE && store_pulse);
	endproperty
	a_save: assert property (p_save) else $error("save sequence wrong"); // R13

	property p_flash;
		@(posedge aclk) disable iff (!aresetn)
		(st_q != spr_pkg::ST_IDLE && !sel_q) |=> indicator_on[0] == $past(blink_q);
	endproperty
	a_flash: assert property (p_flash) else $error("indicator not flashing"); // R14

	property p_flip;
		@(posedge aclk) disable iff (!aresetn)
		(wr_go && aw_addr_q == spr_pkg::A_CTRL) |=> display_flip == $past(wval[0]);
	endproperty
	a_flip: assert property (p_flip) else $error("flip not applied"); // R16
endmodule

// file: spr_operator.sv
// Operator model: push buttons with contact bounce
`timescale 1ns/1ns
module spr_operator (
	input  wire logic aclk,
	output logic [1:0] button_raw
);
	initial button_raw = 2'h0;
	// One-cycle bounce first, shorter than any debounce window
	task automatic press(input int ch, input int n);
		@(posedge aclk);
		button_raw[ch] <= 1'b1;
		@(posedge aclk);
		button_raw[ch] <= 1'b0;
		@(posedge aclk);
		button_raw[ch] <= 1'b1;
		repeat (n) @(posedge aclk);
		button_raw[ch] <= 1'b0;
	endtask
endmodule

// file: test_setpoint_relay_switching.sv
// Testbench: registers, relays and button session against a reference model
`timescale 1ns/1ns
module test_setpoint_relay_switching;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic [15:0] pressure = 16'h1234;
	logic [1:0]  button_raw;
	logic [1:0]  relay_close;
	logic [1:0]  indicator_on;
	logic [15:0] meas_out;
	logic        sw_symbol_blink;
	logic        show_version;
	logic        display_flip;
	logic        store_pulse;
	logic        irq;
	logic [31:0] seed = 32'h12c505be;
	logic [31:0] mdl [0:10];
	logic [31:0] rd_d;
	logic [1:0]  resp;
	logic [15:0] p;
	logic [15:0] r0;
	logic        e;
	logic [1:0]  prv;
	logic [1:0]  seen;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          i;
	int          m;

	// Short timings keep a whole session within a few hundred cycles
	localparam int unsigned SIM_FINE  = 20;
	localparam int unsigned SIM_REVLO = 40;
	localparam int unsigned SIM_REVHI = 60;
	localparam int unsigned SIM_SAVE  = 100;
	localparam int unsigned SIM_SHOW  = 10;
	localparam int unsigned SIM_STEP  = 4;
	localparam int unsigned SIM_DEB   = 3;
	localparam int unsigned SIM_VER   = 8;
	localparam int unsigned SIM_BLINK = 4;

	always #2 aclk = ~aclk;

	spr_top #(.FINE_CYC(SIM_FINE), .REVLO_CYC(SIM_REVLO), .REVHI_CYC(SIM_REVHI),
		.SAVE_CYC(SIM_SAVE), .SHOW_CYC(SIM_SHOW), .STEP_CYC(SIM_STEP), .DEB_CYC(SIM_DEB),
		.VER_CYC(SIM_VER), .BLINK_CYC(SIM_BLINK)) u_spr_top (
		.s_axi_awaddr, .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pressure, .button_raw, .relay_close,
		.indicator_on, .meas_out, .sw_symbol_blink, .show_version, .display_flip,
		.store_pulse, .irq
	);
	spr_operator u_spr_operator (
		.aclk,
		.button_raw
	);

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Response ends the loop; the trailing edge keeps bready from toggling twice
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int k = 0; k < 100 && !done; k++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			error_cnt++;
			stop_test();
		end
		@(posedge aclk);
		if (a <= 8'h28) begin
			for (int b = 0; b < 4; b++) begin
				if (s_axi_wstrb[b]) mdl[a[7:2]][8*b+:8] = d[8*b+:8];
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		bit done;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int k = 0; k < 100 && !done; k++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				resp = s_axi_rresp;
				rd_d = s_axi_rdata;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			error_cnt++;
			stop_test();
		end
		@(posedge aclk);
	endtask

	initial begin
		for (i = 0; i < 11; i++) mdl[i] = 32'h0;
		mdl[2] = 32'h0a0a;
		mdl[10] = spr_pkg::VERSION;
		cyc(12);
		aresetn <= 1'b1;
		cyc(2);
		chk(show_version, 1'b1);
		chk(relay_close, 2'b00);
		for (i = 1; i < 11; i++) begin
			if (i < 7 || i == 10) begin
				rd(8'(i * 4));
				chk(rd_d, mdl[i]);
			end
		end
		chk(show_version, 1'b0);
		rd(8'h2c);
		chk(rd_d, 32'h0);
		chk(resp, spr_pkg::RESP_SLV);
		wr(8'h2c, 32'h1);
		chk(resp, spr_pkg::RESP_SLV);
		wr(spr_pkg::A_CTRL, 32'h1);
		chk(display_flip, 1'b1);
		// Both channels share thresholds; pressures in a hysteresis band are moved out
		for (i = 3; i < 7; i++) wr(8'(i * 4), (i % 2) ? 32'h4000 : 32'hc000);
		for (m = 0; m < 4; m++) begin
			wr(spr_pkg::A_MODE, 32'(m | (m << 2)));
			for (i = 0; i < 8; i++) begin
				p = 16'(rnd());
				if ((p >= 16'h4000 && p <= 16'h4666) || (p >= 16'haccd && p <= 16'hc000))
					p = 16'h8000;
				pressure <= p;
				cyc(3);
				e = (m == 1) ? p > 16'hc000 : (m == 2) ? (p < 16'h4000 || p > 16'hc000)
					: p < 16'h4000;
				chk({relay_close, indicator_on}, {4{e}});
			end
		end
		wr(spr_pkg::A_MODE, 32'h0);
		wr(spr_pkg::A_IRQ_MASK, 32'h1);
		pressure <= 16'h3000;
		cyc(3);
		chk(relay_close, 2'b11);
		wr(spr_pkg::A_IRQ_STAT, 32'h7);
		cyc(2);
		chk(irq, 1'b0);
		pressure <= 16'h4400;
		cyc(3);
		chk(relay_close, 2'b11);
		pressure <= 16'h4700;
		cyc(3);
		chk(relay_close, 2'b00);
		cyc(2);
		chk(irq, 1'b1);
		wr(spr_pkg::A_IRQ_MASK, 32'h0);
		cyc(2);
		chk(irq, 1'b0);
		wr(spr_pkg::A_IRQ_MASK, 32'h1);
		wr(spr_pkg::A_IRQ_STAT, 32'h1);
		cyc(2);
		chk(irq, 1'b0);
		// Button session on channel one in combined mode
		wr(spr_pkg::A_MODE, 32'h2);
		wr(spr_pkg::A_SP1_LO, 32'h0100);
		pressure <= 16'h8000;
		fork
			u_spr_operator.press(0, 30);
			begin
				cyc(14);
				chk(meas_out, 16'h0100);
				seen = 2'b00;
				prv = {sw_symbol_blink, indicator_on[0]};
				repeat (12) begin
					@(posedge aclk);
					seen |= prv ^ {sw_symbol_blink, indicator_on[0]};
					prv = {sw_symbol_blink, indicator_on[0]};
				end
				chk(seen, 2'b11);
			end
		join
		cyc(8);
		r0 = meas_out;
		chk(r0 > 16'h0100, 1'b1);
		u_spr_operator.press(0, 5);
		cyc(10);
		chk(meas_out, r0 + 16'h1);
		cyc(38);
		u_spr_operator.press(0, 5);
		cyc(10);
		chk(meas_out, r0 + 16'h1);
		u_spr_operator.press(0, 5);
		cyc(10);
		chk(meas_out, r0);
		for (i = 0; i < 200 && store_pulse !== 1'b1; i++) @(posedge aclk);
		chk(store_pulse, 1'b1);
		cyc(3);
		chk(meas_out, pressure);
		rd(spr_pkg::A_SP1_LO);
		chk(rd_d, {16'h0, r0});
		rd(spr_pkg::A_SP1_HI);
		chk(rd_d, mdl[4]);
		rd(spr_pkg::A_MODE);
		chk(rd_d, mdl[1]);
		rd(spr_pkg::A_HYST);
		chk(rd_d, mdl[2]);
		rd(spr_pkg::A_IRQ_STAT);
		chk(rd_d[2], 1'b1);
		// Second channel: a short press shows its lower threshold, then times out
		u_spr_operator.press(1, 5);
		cyc(4);
		chk(meas_out, mdl[5]);
		for (i = 0; i < 200 && store_pulse !== 1'b1; i++) @(posedge aclk);
		chk(store_pulse, 1'b1);
		// Byte strobes merge into the stored threshold
		s_axi_wstrb <= 4'h1;
		wr(spr_pkg::A_SP2_HI, rnd());
		s_axi_wstrb <= 4'hf;
		rd(spr_pkg::A_SP2_HI);
		chk(rd_d, mdl[6]);
		stop_test();
	end
endmodule
